/* File: core/port_a_pins.sv */
`timescale 1ns/1ps
// Overview of operation
// - Function-select bit picks GPIO or peripheral pin
// - GPIO direction bit: 0 input, 1 output
// - Reset clears function-select and direction bits
// - Data writes always update output latch
// - GPIO output drives latch, reads latch
// - GPIO input blocks latch, reads pin
// - Dedicated mode ignores direction; peripheral decides
// - Alternate-function bit chooses among dedicated functions
// - Dedicated read returns pin or driver state
// - Unrouted peripheral inputs tied to fixed level
// - Interrupts, receive data, ring 1; clock, address 0
// - Reset-sampled EEPROM select level is inactive level
// - Slave selects negated during EEPROM access
// - Auxiliary chip select is active low
// - Slave select needs GPIO output; returns to latch
// - Negate level 0 low, 1 high
// - Interrupt on two pins is OR of both
module port_a_pins
  import port_a_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire reg_write_type WRITE_I,
  input wire slave_select_control_type SLAVE_CTRL_I,
  input wire logic EE_ACCESS_I,
  input wire logic FRAME_SYNC_MODE_I,
  input wire logic AUX_CS_ACTIVE_I,
  input wire logic [WIDTH-1:0] PERIPH_OUT_I,
  input wire logic [WIDTH-1:0] PERIPH_OE_I,
  input wire logic [WIDTH-1:0] PIN_IN_I,
  output logic [WIDTH-1:0] PIN_OUT_O,
  output logic [WIDTH-1:0] PIN_OE_O,
  output logic [WIDTH-1:0] DATA_RD_O,
  output logic [WIDTH-1:0] FSEL_O,
  output logic [WIDTH-1:0] DIR_O,
  output logic [WIDTH-1:0] ALT_O,
  output logic EE_INACTIVE_O,
  output periph_in_type PERIPH_IN_O
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------

  // Dedicated pins whose function is a peripheral input
  function automatic logic is_dedicated_input(input int idx, input logic alt,
                                              input logic fs_mode);
    logic res;
    res = 1'b0;
    case (idx)
      1, 2, 4: res = 1'b1;
      7, 10, 12, 13, 14, 15: res = 1'b1;
      8: res = !alt || fs_mode;
      9: res = !alt;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : is_dedicated_input

  // Pin routed to a peripheral input: dedicated and with matching alternate bit
  function automatic logic routed(input logic fsel, input logic alt, input logic want_alt);
    return fsel && (alt == want_alt);
  endfunction : routed

  // ----------------------------------------------------------------
  // Configuration registers and output latch
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] fsel_r;
  logic [WIDTH-1:0] dir_r;
  logic [WIDTH-1:0] alt_r;
  logic [WIDTH-1:0] latch_r;
  logic ee_inactive_r;
  logic ee_sampled_r;

  // Function select and direction start cleared: every pin a GPIO input
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fsel_r <= FSEL_RESET;
      dir_r <= DIR_RESET;
    end else begin
      if (WRITE_I.wr_fsel) begin
        fsel_r <= WRITE_I.wdata[WIDTH-1:0];
      end
      if (WRITE_I.wr_dir) begin
        dir_r <= WRITE_I.wdata[WIDTH-1:0];
      end
    end
  end

  // Alternate function bits
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      alt_r <= ALT_RESET;
    end else if (WRITE_I.wr_alt) begin
      alt_r <= WRITE_I.wdata[WIDTH-1:0];
    end
  end

  // Latch takes every data write, whatever the pin mode
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      latch_r <= LATCH_RESET;
    end else if (WRITE_I.wr_data) begin
      latch_r <= WRITE_I.wdata[WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // EEPROM select level capture
  // ----------------------------------------------------------------

  // The pin cannot be sampled under async reset, so the first edge after
  // release catches it; pin 0 is still a GPIO input at that edge.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ee_sampled_r <= 1'b0;
      ee_inactive_r <= 1'b0;
    end else if (!ee_sampled_r) begin
      ee_sampled_r <= 1'b1;
      ee_inactive_r <= PIN_IN_I[PIN_EE_SEL];
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and read-back
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] out_nxt;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] rd_nxt;

  always_comb begin
    out_nxt = '0;
    oe_nxt = '0;
    rd_nxt = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (!fsel_r[i]) begin
        // GPIO: direction bit alone decides
        oe_nxt[i] = dir_r[i];
        out_nxt[i] = latch_r[i];
        rd_nxt[i] = dir_r[i] ? latch_r[i] : PIN_IN_I[i];
      end else begin
        // Dedicated: direction bit ignored, peripheral owns the pin
        if (i == PIN_EE_SEL) begin
          oe_nxt[i] = 1'b1;
          out_nxt[i] = EE_ACCESS_I ? !ee_inactive_r : ee_inactive_r;
        end else if (i == PIN_AUX_CS) begin
          oe_nxt[i] = 1'b1;
          out_nxt[i] = !AUX_CS_ACTIVE_I;
        end else if (is_dedicated_input(i, alt_r[i], FRAME_SYNC_MODE_I)) begin
          oe_nxt[i] = 1'b0;
        end else begin
          oe_nxt[i] = PERIPH_OE_I[i];
          out_nxt[i] = PERIPH_OUT_I[i];
        end
        rd_nxt[i] = oe_nxt[i] ? out_nxt[i] : PIN_IN_I[i];
      end
    end
    // Slave selects ride on GPIO outputs and are overridden only during
    // an EEPROM access, so the latch level reappears once it ends.
    for (int k = 0; k < SLAVE_COUNT; k++) begin
      if (!fsel_r[SLAVE_PIN_LO + k] && dir_r[SLAVE_PIN_LO + k] &&
          SLAVE_CTRL_I.enable[k] && EE_ACCESS_I) begin
        out_nxt[SLAVE_PIN_LO + k] = SLAVE_CTRL_I.negate_level[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Peripheral input routing
  // ----------------------------------------------------------------
  periph_in_type pin_nxt;
  logic [6:1] irq_any;
  logic [6:1] irq_or;

  // Each interrupt ORs every pin routed to it; with none routed it idles
  always_comb begin
    irq_any = '0;
    irq_or = '0;
    if (routed(fsel_r[PIN_IRQ1_CLK], alt_r[PIN_IRQ1_CLK], 1'b0)) begin
      irq_any[1] = 1'b1;
      irq_or[1] = PIN_IN_I[PIN_IRQ1_CLK];
    end
    for (int n = 2; n <= 4; n++) begin
      if (routed(fsel_r[PIN_IRQ2_STB + n - 2], alt_r[PIN_IRQ2_STB + n - 2], 1'b0)) begin
        irq_any[n] = 1'b1;
        irq_or[n] = irq_or[n] | PIN_IN_I[PIN_IRQ2_STB + n - 2];
      end
    end
    for (int n = 2; n <= 5; n++) begin
      if (routed(fsel_r[PIN_ADDR_LO + n - 2], alt_r[PIN_ADDR_LO + n - 2], 1'b0)) begin
        irq_any[n] = 1'b1;
        irq_or[n] = irq_or[n] | PIN_IN_I[PIN_ADDR_LO + n - 2];
      end
    end
    if (fsel_r[PIN_IRQ5_A]) begin
      irq_any[5] = 1'b1;
      irq_or[5] = irq_or[5] | PIN_IN_I[PIN_IRQ5_A];
    end
    if (fsel_r[PIN_IRQ6]) begin
      irq_any[6] = 1'b1;
      irq_or[6] = PIN_IN_I[PIN_IRQ6];
    end
  end

  // Unrouted inputs see a fixed level and leave the GPIO pin untouched
  always_comb begin
    for (int n = 1; n <= 6; n++) begin
      pin_nxt.ext_irq_in[n] = irq_any[n] ? irq_or[n] : IRQ_DEFAULT;
    end
    pin_nxt.rx_data = fsel_r[PIN_RX_DATA] ? PIN_IN_I[PIN_RX_DATA] : RX_DATA_DEFAULT;
    pin_nxt.serial_rx_clock_in = routed(fsel_r[PIN_IRQ1_CLK], alt_r[PIN_IRQ1_CLK], 1'b1) ?
                                 PIN_IN_I[PIN_IRQ1_CLK] : RX_CLOCK_DEFAULT;
    pin_nxt.ring_indicate = routed(fsel_r[PIN_IRQ4_RING], alt_r[PIN_IRQ4_RING], 1'b1) ?
                            PIN_IN_I[PIN_IRQ4_RING] : RING_DEFAULT;
    pin_nxt.codec_frame_sync =
        (routed(fsel_r[PIN_IRQ2_STB], alt_r[PIN_IRQ2_STB], 1'b1) && FRAME_SYNC_MODE_I) ?
        PIN_IN_I[PIN_IRQ2_STB] : FRAME_SYNC_DEFAULT;
    for (int a = 0; a < ADDR_HI_COUNT; a++) begin
      pin_nxt.addr_hi[a] = routed(fsel_r[PIN_ADDR_LO + a], alt_r[PIN_ADDR_LO + a], 1'b1) ?
                           PIN_IN_I[PIN_ADDR_LO + a] : ADDR_HI_DEFAULT[a];
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------

  // One cycle of latency on every output, bought for clean timing at pins
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PIN_OUT_O <= '0;
      PIN_OE_O <= '0;
      DATA_RD_O <= '0;
      PERIPH_IN_O <= '0;
    end else begin
      PIN_OUT_O <= out_nxt;
      PIN_OE_O <= oe_nxt;
      DATA_RD_O <= rd_nxt;
      PERIPH_IN_O <= pin_nxt;
    end
  end

  // Configuration read-back
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FSEL_O <= FSEL_RESET;
      DIR_O <= DIR_RESET;
      ALT_O <= ALT_RESET;
      EE_INACTIVE_O <= 1'b0;
    end else begin
      FSEL_O <= fsel_r;
      DIR_O <= dir_r;
      ALT_O <= alt_r;
      EE_INACTIVE_O <= ee_inactive_r;
    end
  end

endmodule : port_a_pins

/* File: include/port_a_pkg.sv */
package port_a_pkg;

  // ----------------------------------------------------------------
  // Widths and pin positions
  // ----------------------------------------------------------------
  localparam int PORT_WIDTH = 16;
  localparam int PIN_EE_SEL = 0;
  localparam int PIN_IRQ5_A = 1;
  localparam int PIN_IRQ6 = 2;
  localparam int PIN_RX_DATA = 4;
  localparam int PIN_IRQ1_CLK = 7;
  localparam int PIN_IRQ2_STB = 8;
  localparam int PIN_IRQ3_STB = 9;
  localparam int PIN_IRQ4_RING = 10;
  localparam int PIN_AUX_CS = 11;
  localparam int PIN_ADDR_LO = 12;
  localparam int SLAVE_PIN_LO = 1;
  localparam int SLAVE_COUNT = 3;
  localparam int ADDR_HI_COUNT = 4;

  // ----------------------------------------------------------------
  // Reset values and default levels of unrouted peripheral inputs
  // ----------------------------------------------------------------
  localparam logic [15:0] FSEL_RESET = 16'h0000;
  localparam logic [15:0] DIR_RESET = 16'h0000;
  localparam logic [15:0] ALT_RESET = 16'hF000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic IRQ_DEFAULT = 1'h1;
  localparam logic RX_DATA_DEFAULT = 1'h1;
  localparam logic RING_DEFAULT = 1'h1;
  localparam logic RX_CLOCK_DEFAULT = 1'h0;
  localparam logic [3:0] ADDR_HI_DEFAULT = 4'h0;
  localparam logic FRAME_SYNC_DEFAULT = 1'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_fsel;
    logic wr_dir;
    logic wr_alt;
    logic wr_data;
    logic [15:0] wdata;
  } reg_write_type;

  typedef struct packed {
    logic [6:1] ext_irq_in;   // ext_irq_in_1 .. ext_irq_in_6
    logic rx_data;
    logic serial_rx_clock_in;
    logic ring_indicate;
    logic codec_frame_sync;
    logic [3:0] addr_hi;      // address bits 20 to 23
  } periph_in_type;

  typedef struct packed {
    logic [2:0] enable;       // slave select enable, pins 1 to 3
    logic [2:0] negate_level; // slave_negate_level, pins 1 to 3
  } slave_select_control_type;

endpackage : port_a_pkg

/* File: verification/port_a_pins_sva.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker: config read-back and pins share one latency
// ------------------------------------------------------------
module port_a_pins_sva
  import port_a_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire slave_select_control_type SLAVE_CTRL_I,
  input wire logic EE_ACCESS_I,
  input wire logic AUX_CS_ACTIVE_I,
  input wire logic [WIDTH-1:0] PIN_IN_I,
  input wire logic [WIDTH-1:0] PIN_OUT_O,
  input wire logic [WIDTH-1:0] PIN_OE_O,
  input wire logic [WIDTH-1:0] FSEL_O,
  input wire logic [WIDTH-1:0] DIR_O,
  input wire logic [WIDTH-1:0] ALT_O,
  input wire logic EE_INACTIVE_O,
  input wire periph_in_type PERIPH_IN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // Config unchanged for a cycle, so pins and read-back agree
  sequence steady_cfg;
    $past(NRST_I) && $stable(FSEL_O) && $stable(ALT_O) && $stable(DIR_O);
  endsequence
  // Slave pin 1 is a GPIO output with an EEPROM access running
  sequence slave_forced;
    steady_cfg ##0 (!FSEL_O[1] && DIR_O[1] && $past(SLAVE_CTRL_I.enable[0])
      && $past(EE_ACCESS_I));
  endsequence
  a_reset_gpio_in: assert property ($rose(NRST_I) |-> FSEL_O == '0 && DIR_O == '0)
    else $error("config not cleared after reset");
  a_gpio_dir_oe: assert property (steady_cfg |-> ((~FSEL_O) & (PIN_OE_O ^ DIR_O)) == '0)
    else $error("gpio drive enable differs from direction");
  a_rx_not_driven: assert property (steady_cfg ##0 FSEL_O[4] |-> !PIN_OE_O[4])
    else $error("receive data pin driven in dedicated mode");
  a_periph_defaults: assert property (steady_cfg ##0 FSEL_O == '0 |->
    PERIPH_IN_O == {6'h3F, 1'h1, 1'h0, 1'h1, 1'h0, 4'h0})
    else $error("unrouted peripheral inputs wrong");
  a_rx_routed: assert property (steady_cfg ##0 FSEL_O[4] |->
    PERIPH_IN_O.rx_data == $past(PIN_IN_I[4]))
    else $error("receive data not taken from pin");
  a_irq_two_pins: assert property (steady_cfg ##0 (FSEL_O[8] && FSEL_O[12] && !ALT_O[8]
    && !ALT_O[12]) |-> PERIPH_IN_O.ext_irq_in[2] == ($past(PIN_IN_I[8]) | $past(PIN_IN_I[12])))
    else $error("interrupt two is not the or of both pins");
  a_slave_negate: assert property (slave_forced |->
    PIN_OUT_O[1] == $past(SLAVE_CTRL_I.negate_level[0]))
    else $error("slave select not negated during eeprom access");
  a_aux_cs_low: assert property (steady_cfg ##0 FSEL_O[11] |->
    PIN_OE_O[11] && PIN_OUT_O[11] == !$past(AUX_CS_ACTIVE_I))
    else $error("aux chip select level wrong");
  a_ee_select_lvl: assert property (steady_cfg ##0 FSEL_O[0] |->
    PIN_OE_O[0] && PIN_OUT_O[0] == (EE_INACTIVE_O ^ $past(EE_ACCESS_I)))
    else $error("eeprom select level wrong");
endmodule : port_a_pins_sva

bind port_a_pins port_a_pins_sva #(.WIDTH(WIDTH)) port_a_pins_sva_i (.CLK_I(CLK_I),
  .NRST_I(NRST_I), .SLAVE_CTRL_I(SLAVE_CTRL_I), .EE_ACCESS_I(EE_ACCESS_I),
  .AUX_CS_ACTIVE_I(AUX_CS_ACTIVE_I), .PIN_IN_I(PIN_IN_I), .PIN_OUT_O(PIN_OUT_O),
  .PIN_OE_O(PIN_OE_O), .FSEL_O(FSEL_O), .DIR_O(DIR_O), .ALT_O(ALT_O),
  .EE_INACTIVE_O(EE_INACTIVE_O), .PERIPH_IN_O(PERIPH_IN_O));

/* File: verification/port_a_pins_tb.sv */
`timescale 1ns/1ps
module port_a_pins_tb
  import port_a_pkg::*;
;
  logic clk = 1'b0;
  logic nrst_n = 1'b0;
  reg_write_type wr = '0;
  slave_select_control_type sctl = '0;
  logic ee_acc = 1'b0;
  logic aux_act = 1'b0;
  logic fs_mode = 1'b0;
  logic [15:0] pin_in = 16'h0001;
  logic [15:0] pin_out, pin_oe, data_rd, fsel, dir, alt;
  logic ee_inact;
  periph_in_type periph;
  logic [15:0] vals [4] = '{16'h0000, 16'h1000, 16'h0100, 16'h6E96};
  int failures = 0;
  int samples_checked = 0;

  // Clock at 10 MHz
  always #50 clk = ~clk;

  port_a_pins port_a_pins_i (.CLK_I(clk), .NRST_I(nrst_n), .WRITE_I(wr), .SLAVE_CTRL_I(sctl),
    .EE_ACCESS_I(ee_acc), .FRAME_SYNC_MODE_I(fs_mode), .AUX_CS_ACTIVE_I(aux_act),
    .PERIPH_OUT_I(16'h0020), .PERIPH_OE_I(16'h0020), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
    .PIN_OE_O(pin_oe), .DATA_RD_O(data_rd), .FSEL_O(fsel), .DIR_O(dir), .ALT_O(alt),
    .EE_INACTIVE_O(ee_inact), .PERIPH_IN_O(periph));

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle strobes; strobe order is fsel, dir, alt, data
  task automatic wrt(input logic [3:0] strobes, input logic [15:0] d);
    @(posedge clk);
    wr <= {strobes, d};
    @(posedge clk);
    wr <= '0;
  endtask : wrt

  // Sample at the falling edge so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Expected peripheral inputs with every pin dedicated
  function automatic logic [13:0] exp_periph(input logic [15:0] v, input logic hi);
    logic [6:1] q;
    q[1] = v[7];
    q[2] = v[8] | (v[12] & !hi);
    q[3] = v[9] | (v[13] & !hi);
    q[4] = v[10] | (v[14] & !hi);
    q[5] = v[1] | (v[15] & !hi);
    q[6] = v[2];
    return {q, v[4], 1'b0, 1'b1, 1'b0, (hi ? v[15:12] : 4'h0)};
  endfunction : exp_periph

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst_n <= 1'b1;
    settle(3);
    chk("fsel", FSEL_RESET, fsel);
    chk("dir", DIR_RESET, dir);
    chk("alt", ALT_RESET, alt);
    chk("ee_inactive", 16'h0001, ee_inact);
    chk("periph_default", 16'h3FA0, periph);
    $display("test reset done");
    wrt(4'b0001, 16'hA5C3);
    wrt(4'b0100, 16'h00FF);
    pin_in <= 16'h1235;
    settle(3);
    chk("gpio_oe", 16'h00FF, pin_oe);
    chk("gpio_out", 16'h00C3, pin_out & 16'h00FF);
    chk("gpio_read", 16'h12C3, data_rd);
    $display("test gpio done");
    // Negate levels 1,0,1 on pins 3..1 while the EEPROM is busy
    @(posedge clk);
    sctl <= 6'b111101;
    ee_acc <= 1'b1;
    settle(2);
    chk("slave_negated", 16'h000A, pin_out & 16'h000E);
    @(posedge clk);
    ee_acc <= 1'b0;
    settle(2);
    chk("slave_released", 16'h0002, pin_out & 16'h000E);
    @(posedge clk);
    sctl <= '0;
    $display("test slave done");
    wrt(4'b1000, 16'hFFFF);
    wrt(4'b0010, 16'h0000);
    foreach (vals[k]) begin
      @(posedge clk);
      pin_in <= vals[k];
      settle(2);
      chk("periph_alt0", {2'b00, exp_periph(vals[k], 1'b0)}, periph);
    end
    wrt(4'b0010, 16'hF000);
    @(posedge clk);
    pin_in <= 16'hA000;
    settle(3);
    chk("periph_alt1", {2'b00, exp_periph(16'hA000, 1'b1)}, periph);
    @(posedge clk);
    aux_act <= 1'b1;
    ee_acc <= 1'b1;
    settle(2);
    chk("ded_pins", 16'h00AE, {pin_oe[11], pin_out[11], pin_oe[0], pin_out[0],
      pin_oe[5], pin_out[5], data_rd[5], pin_oe[4]});
    // Pin 8 with its alternate bit set and frame sync mode on becomes the codec frame sync input
    wrt(4'b0010, 16'hF100);
    @(posedge clk);
    fs_mode <= 1'b1;
    pin_in <= 16'h0100;
    settle(3);
    chk("frame_sync", 16'h0001, periph.codec_frame_sync);
    chk("frame_sync_oe", 16'h0000, pin_oe[8]);
    $display("test dedicated done");
    tally_and_finish;
  end

  // Tests need about 55 cycles; allow 2000
  initial begin
    #200000;
    failures++;
    tally_and_finish;
  end
endmodule : port_a_pins_tb
